// file: src/sbpb_pkg.sv
// Constants and carrier types of the basic servo parameter bank
package sbpb_pkg;
  localparam int          SBPB_NPARAM  = 9;
  // Parameter numbers inside the basic group
  localparam logic [6:0]  PN_REGEN     = 7'h02;
  localparam logic [6:0]  PN_ABSPOS    = 7'h03;
  localparam logic [6:0]  PN_FUNC_A1   = 7'h04;
  localparam logic [6:0]  PN_TUNE_MODE = 7'h08;
  localparam logic [6:0]  PN_TUNE_RESP = 7'h09;
  localparam logic [6:0]  PN_POS_WIN   = 7'h0A;
  localparam logic [6:0]  PN_ROT_SENSE = 7'h0E;
  localparam logic [6:0]  PN_QUAD_CNT  = 7'h0F;
  localparam logic [6:0]  PN_WPROT     = 7'h13;
  // Storage slots
  localparam logic [3:0]  IX_REGEN     = 4'h0;
  localparam logic [3:0]  IX_ABSPOS    = 4'h1;
  localparam logic [3:0]  IX_FUNC_A1   = 4'h2;
  localparam logic [3:0]  IX_TUNE_MODE = 4'h3;
  localparam logic [3:0]  IX_TUNE_RESP = 4'h4;
  localparam logic [3:0]  IX_POS_WIN   = 4'h5;
  localparam logic [3:0]  IX_ROT_SENSE = 4'h6;
  localparam logic [3:0]  IX_QUAD_CNT  = 4'h7;
  localparam logic [3:0]  IX_WPROT     = 4'h8;
  localparam logic [3:0]  IX_NONE      = 4'hF;
  // Values after reset
  localparam logic [15:0] RST_REGEN     = 16'h0000;
  localparam logic [15:0] RST_ABSPOS    = 16'h0000;
  localparam logic [15:0] RST_FUNC_A1   = 16'h0000;
  localparam logic [15:0] RST_TUNE_MODE = 16'h0001;
  localparam logic [15:0] RST_TUNE_RESP = 16'h000C;
  localparam logic [15:0] RST_POS_WIN   = 16'h0064;
  localparam logic [15:0] RST_ROT_SENSE = 16'h0000;
  localparam logic [15:0] RST_QUAD_CNT  = 16'h0FA0;
  localparam logic [15:0] RST_WPROT     = 16'h000B;
  // Write-inhibit settings
  localparam logic [15:0] WP_STD       = 16'h000B;
  localparam logic [15:0] WP_ALL       = 16'h000C;
  localparam logic [15:0] WP_RD_ALL    = 16'h100C;
  localparam logic [15:0] WP_SELF_ONLY = 16'h100B;
  // Response range and error code
  localparam logic [15:0] RESP_MIN     = 16'h0001;
  localparam logic [15:0] RESP_MAX     = 16'h0020;
  localparam logic [7:0]  ERR_REGEN    = 8'h25;
  // Halt selector field position and off value
  localparam int          HALT_SEL_LSB = 8;
  localparam logic [3:0]  HALT_SEL_OFF = 4'h1;

  typedef enum logic [1:0] {GRP_BASIC, GRP_GAIN, GRP_EXT, GRP_IO} sbpb_grp_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_ctrl;
    sbpb_grp_t   group;
    logic [6:0]  num;
    logic [15:0] data;
  } sbpb_req_t;

  typedef struct packed {
    logic        done;
    logic        granted;
    logic [15:0] rdata;
  } sbpb_rsp_t;

  typedef struct packed {
    logic [15:0] regen;
    logic [15:0] func_a1;
    logic [15:0] tune_mode;
    logic [15:0] tune_resp;
    logic [15:0] pos_win;
    logic        rot_sense;
    logic [15:0] quad_cnt;
    logic [15:0] wprot;
  } sbpb_eff_t;
endpackage : sbpb_pkg

// file: src/sbpb_bank.sv
// Basic servo parameter bank with write inhibit and staged activation
`timescale 1ns/100ps
module sbpb_bank
#(
  parameter logic [7:0] REGEN_MAX = 8'h0F
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              nv_init,
  input  wire logic              ctrl_reset,
  input  wire logic              position_mode,
  input  wire logic              emergency_halt_input,
  input  wire sbpb_pkg::sbpb_req_t req,
  output      sbpb_pkg::sbpb_rsp_t rsp,
  output      sbpb_pkg::sbpb_eff_t eff,
  output      logic              absolute_mode,
  output      logic              halt_released,
  output      logic              param_error,
  output      logic [7:0]        error_code
);
  import sbpb_pkg::*;

  logic [15:0] stg [SBPB_NPARAM];
  logic [15:0] act [SBPB_NPARAM];
  logic        boot_load;
  logic        halt_s1;
  logic        halt_s2;
  logic [3:0]  ix;
  logic        rd_ok;
  logic        wr_ok;
  logic        val_ok;

  function automatic logic [3:0] slot_of(input logic [6:0] n);
    unique case (n)
      PN_REGEN:     slot_of = IX_REGEN;
      PN_ABSPOS:    slot_of = IX_ABSPOS;
      PN_FUNC_A1:   slot_of = IX_FUNC_A1;
      PN_TUNE_MODE: slot_of = IX_TUNE_MODE;
      PN_TUNE_RESP: slot_of = IX_TUNE_RESP;
      PN_POS_WIN:   slot_of = IX_POS_WIN;
      PN_ROT_SENSE: slot_of = IX_ROT_SENSE;
      PN_QUAD_CNT:  slot_of = IX_QUAD_CNT;
      PN_WPROT:     slot_of = IX_WPROT;
      default:      slot_of = IX_NONE;
    endcase
  endfunction : slot_of

  function automatic logic [15:0] dflt(input int i);
    logic [15:0] d [SBPB_NPARAM];
    d = '{RST_REGEN, RST_ABSPOS, RST_FUNC_A1, RST_TUNE_MODE, RST_TUNE_RESP,
          RST_POS_WIN, RST_ROT_SENSE, RST_QUAD_CNT, RST_WPROT};
    dflt = d[i];
  endfunction : dflt

  // Access gate from the active inhibit word
  always_comb
  begin
    ix    = slot_of(req.num);
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    unique case (act[IX_WPROT])
      WP_STD:
      begin
        rd_ok = (req.group != GRP_IO);
        wr_ok = (req.group != GRP_IO);
      end
      WP_ALL:
      begin
        rd_ok = 1'b1;
        wr_ok = 1'b1;
      end
      WP_RD_ALL:
      begin
        rd_ok = 1'b1;
        wr_ok = (req.group == GRP_BASIC) && (ix == IX_WPROT);
      end
      default:
      begin
        // Unknown settings still let the inhibit word itself be rewritten
        wr_ok = (req.group == GRP_BASIC) && (ix == IX_WPROT);
      end
    endcase
    if (req.from_ctrl)
    begin
      rd_ok = 1'b1;
      wr_ok = 1'b1;
    end
    // Range applies to the basic-group response only, not same-numbered peers
    val_ok = !(ix == IX_TUNE_RESP && req.group == GRP_BASIC &&
               (req.data < RESP_MIN || req.data > RESP_MAX));
  end

  // Staged (nonvolatile) copy; survives sys_rst like parameter memory
  always_ff @(posedge clk)
  begin
    if (nv_init)
    begin
      for (int i = 0; i < SBPB_NPARAM; i++)
        stg[i] <= dflt(i);
    end
    else if (req.valid && req.write && wr_ok && val_ok &&
             req.group == GRP_BASIC && ix != IX_NONE)
    begin
      stg[ix] <= req.data;
    end
  end

  // Active copy: double-star loads only on the boot pass
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      boot_load <= 1'b1;
      for (int i = 0; i < SBPB_NPARAM; i++)
        act[i] <= dflt(i);
    end
    else
    begin
      boot_load <= 1'b0;
      if (boot_load)
      begin
        for (int i = 0; i < SBPB_NPARAM; i++)
          act[i] <= stg[i];
      end
      else if (ctrl_reset)
      begin
        for (int i = 1; i < SBPB_NPARAM; i++)
          act[i] <= stg[i];
      end
    end
  end

  // Response; blocked access answers with granted low and zero data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rsp <= '0;
    else
    begin
      rsp.done    <= req.valid;
      rsp.granted <= req.valid && (req.write ? (wr_ok && val_ok) : rd_ok);
      rsp.rdata   <= (req.valid && !req.write && rd_ok &&
                      req.group == GRP_BASIC && ix != IX_NONE) ?
                     stg[ix] : 16'h0000;
    end
  end

  // Pin synchroniser
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end
    else
    begin
      halt_s1 <= emergency_halt_input;
      halt_s2 <= halt_s1;
    end
  end

  // Derived outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      eff           <= '0;
      absolute_mode <= 1'b0;
      halt_released <= 1'b0;
      param_error   <= 1'b0;
      error_code    <= 8'h00;
    end
    else
    begin
      eff.regen     <= act[IX_REGEN];
      eff.func_a1   <= act[IX_FUNC_A1];
      eff.tune_mode <= act[IX_TUNE_MODE];
      eff.tune_resp <= act[IX_TUNE_RESP];
      eff.pos_win   <= act[IX_POS_WIN];
      eff.rot_sense <= act[IX_ROT_SENSE][0];
      eff.quad_cnt  <= act[IX_QUAD_CNT];
      eff.wprot     <= act[IX_WPROT];
      absolute_mode <= act[IX_ABSPOS][0] && position_mode;
      halt_released <= (act[IX_FUNC_A1][HALT_SEL_LSB +: 4] == HALT_SEL_OFF)
                       || halt_s2;
      param_error   <= act[IX_REGEN][7:0] > REGEN_MAX;
      error_code    <= (act[IX_REGEN][7:0] > REGEN_MAX) ? ERR_REGEN : 8'h00;
    end
  end

  // Checks
  property p_blocked_io;
    @(posedge clk) disable iff (sys_rst)
      req.valid && !req.from_ctrl && req.group == GRP_IO &&
      act[IX_WPROT] == WP_STD |=> rsp.done && !rsp.granted;
  endproperty
  a_blocked_io: assert property (p_blocked_io)
    else $error("I/O group reachable under standard inhibit");

  property p_all_open;
    @(posedge clk) disable iff (sys_rst)
      req.valid && act[IX_WPROT] == WP_ALL && !req.write |=> rsp.granted;
  endproperty
  a_all_open: assert property (p_all_open)
    else $error("Read refused under open inhibit");

  property p_self_only;
    @(posedge clk) disable iff (sys_rst)
      req.valid && req.write && !req.from_ctrl &&
      act[IX_WPROT] == WP_RD_ALL && ix != IX_WPROT |=> !rsp.granted;
  endproperty
  a_self_only: assert property (p_self_only)
    else $error("Write accepted under read-only inhibit");

  property p_ctrl_bypass;
    @(posedge clk) disable iff (sys_rst)
      req.valid && req.from_ctrl && !req.write |=> rsp.granted;
  endproperty
  a_ctrl_bypass: assert property (p_ctrl_bypass)
    else $error("Controller access refused");

  property p_regen_held;
    @(posedge clk) disable iff (sys_rst)
      !boot_load |=> act[IX_REGEN] == $past(act[IX_REGEN]);
  endproperty
  a_regen_held: assert property (p_regen_held)
    else $error("Regeneration selection changed without power cycle");

  property p_star_held;
    @(posedge clk) disable iff (sys_rst)
      !boot_load && !ctrl_reset |=> $stable(act[IX_ABSPOS]);
  endproperty
  a_star_held: assert property (p_star_held)
    else $error("Single-star parameter changed without reset");

  property p_err37;
    @(posedge clk) disable iff (sys_rst)
      act[IX_REGEN][7:0] > REGEN_MAX |=> param_error && error_code == 8'h25;
  endproperty
  a_err37: assert property (p_err37)
    else $error("Invalid regeneration selection not flagged");

  property p_abs_speed;
    @(posedge clk) disable iff (sys_rst)
      !position_mode |=> !absolute_mode;
  endproperty
  a_abs_speed: assert property (p_abs_speed)
    else $error("Absolute mode active outside position control");

  property p_halt_forced;
    @(posedge clk) disable iff (sys_rst)
      act[IX_FUNC_A1][11:8] == 4'h1 |=> halt_released;
  endproperty
  a_halt_forced: assert property (p_halt_forced)
    else $error("Halt input not forced on");

  property p_resp_range;
    @(posedge clk) disable iff (sys_rst)
      req.valid && req.write && ix == IX_TUNE_RESP &&
      req.group == GRP_BASIC &&
      (req.data == 16'h0000 || req.data > 16'h0020) |=> !rsp.granted;
  endproperty
  a_resp_range: assert property (p_resp_range)
    else $error("Out-of-range tuning response accepted");

  property p_blocked_keep;
    @(posedge clk) disable iff (sys_rst)
      req.valid && req.write && !wr_ok && !nv_init && ix != IX_NONE
      |=> stg[$past(ix)] == $past(stg[ix]);
  endproperty
  a_blocked_keep: assert property (p_blocked_keep)
    else $error("Blocked write changed a parameter");
endmodule : sbpb_bank

// file: sim/sbpb_host.sv
// Behavioural parameter controller on the far side of the bank
`timescale 1ns/100ps
module sbpb_host
#(
  parameter bit LARGE_UNIT = 1'b0
)
(
  input  wire logic                clk,
  input  wire sbpb_pkg::sbpb_rsp_t rsp,
  output      sbpb_pkg::sbpb_req_t req
);
  import sbpb_pkg::*;
  initial req = '0;
  // Only listed parameter numbers are ever sent
  task automatic access(input logic wr, input logic fc, input sbpb_grp_t g,
    input logic [6:0] n, input logic [15:0] d, input int gap,
    output sbpb_rsp_t r);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    if (LARGE_UNIT && g == GRP_BASIC && n == PN_REGEN)
      d[7:0] = 8'h00;
    req = '{1'b1, wr, fc, g, n, d};
    @(posedge clk);
    @(negedge clk);
    r = rsp;
    // Released lines carry inverted junk, never the last request
    req = '{1'b0, ~wr, ~fc, sbpb_grp_t'(~g), ~n, ~d};
  endtask : access
endmodule : sbpb_host

// file: sim/tb.sv
// Self-checking bench of the basic servo parameter bank
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import sbpb_pkg::*;
  logic       clk, sys_rst, nv_init, ctrl_reset, position_mode, halt_in;
  sbpb_req_t  req;
  sbpb_rsp_t  rsp, r;
  sbpb_eff_t  eff, ee;
  logic       absolute_mode, halt_released, param_error;
  logic [7:0] error_code;
  logic [15:0] wp, sw, v, tr;
  int         mismatches, checks_done;
  logic [6:0]  nums [9] = '{PN_REGEN, PN_ABSPOS, PN_FUNC_A1, PN_TUNE_MODE,
    PN_TUNE_RESP, PN_POS_WIN, PN_ROT_SENSE, PN_QUAD_CNT, PN_WPROT};
  logic [15:0] rsts [9] = '{RST_REGEN, RST_ABSPOS, RST_FUNC_A1,
    RST_TUNE_MODE, RST_TUNE_RESP, RST_POS_WIN, RST_ROT_SENSE, RST_QUAD_CNT,
    RST_WPROT};
  logic [15:0] resp_vals [5] = '{16'h0000, 16'h0021, 16'h0001, 16'h0020,
    16'h0007};

  sbpb_bank dut_u (.clk(clk), .sys_rst(sys_rst), .nv_init(nv_init),
    .ctrl_reset(ctrl_reset), .position_mode(position_mode),
    .emergency_halt_input(halt_in), .req(req), .rsp(rsp), .eff(eff),
    .absolute_mode(absolute_mode), .halt_released(halt_released),
    .param_error(param_error), .error_code(error_code));
  sbpb_host host_u (.clk(clk), .rsp(rsp), .req(req));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic exp_grant(input logic [15:0] w, input logic wr,
    input logic fc, input sbpb_grp_t g, input logic [6:0] n,
    input logic [15:0] d);
    logic self;
    self = (g == GRP_BASIC) && (n == PN_WPROT);
    if (wr && g == GRP_BASIC && n == PN_TUNE_RESP &&
        (d < RESP_MIN || d > RESP_MAX)) return 1'b0;
    if (fc || w == WP_ALL) return 1'b1;
    if (w == WP_STD) return g != GRP_IO;
    if (w == WP_RD_ALL) return !wr || self;
    return wr && self;
  endfunction : exp_grant

  task automatic op(input logic wr, input logic fc, input sbpb_grp_t g,
    input logic [6:0] n, input logic [15:0] d, input logic [15:0] erd);
    logic eg;
    eg = exp_grant(wp, wr, fc, g, n, d);
    host_u.access(wr, fc, g, n, d, $urandom_range(2), r);
    `CHK(r.done, 1'b1)
    `CHK(r.granted, eg)
    if (!wr) `CHK(r.rdata, eg ? erd : 16'h0000)
  endtask : op

  task automatic creset();
    @(negedge clk);
    ctrl_reset = 1'b1;
    @(negedge clk);
    ctrl_reset = 1'b0;
    repeat (3) @(negedge clk);
    wp = sw;
  endtask : creset

  task automatic power(input int hold);
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (hold) @(negedge clk);
    sys_rst = 1'b0;
    nv_init = 1'b0;
    repeat (3) @(negedge clk);
    wp = sw;
  endtask : power

  // Both access kinds on all groups, basic side via the inhibit word
  task automatic sweep();
    for (int i = 0; i < 8; i++)
      op(i[0], 1'b0, sbpb_grp_t'(i[2:1]), PN_WPROT, sw,
         i[2:1] == 2'd0 ? sw : 16'h0000);
  endtask : sweep

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    #400us;
    mismatches++;
    test_done();
  end

  initial
  begin
    {sys_rst, nv_init, ctrl_reset, position_mode, halt_in} = 5'b11001;
    mismatches = 0;
    checks_done = 0;
    v = $urandom(95093);
    sw = WP_STD;
    power(8);
    ee = '{RST_REGEN, RST_FUNC_A1, RST_TUNE_MODE, RST_TUNE_RESP,
      RST_POS_WIN, RST_ROT_SENSE[0], RST_QUAD_CNT, RST_WPROT};
    `CHK(eff, ee)
    `CHK({absolute_mode, halt_released, param_error}, 3'b010)
    for (int i = 0; i < 9; i++) op(1'b0, 1'b0, GRP_BASIC, nums[i], 0, rsts[i]);
    sweep();
    $display("test reset and factory gate done");
    tr = RST_TUNE_RESP;
    foreach (resp_vals[i])
    begin
      op(1'b1, 1'b0, GRP_BASIC, PN_TUNE_RESP, resp_vals[i], 0);
      if (exp_grant(wp, 1'b1, 1'b0, GRP_BASIC, PN_TUNE_RESP, resp_vals[i]))
        tr = resp_vals[i];
      op(1'b0, 1'b0, GRP_BASIC, PN_TUNE_RESP, 0, tr);
    end
    $display("test response range done");
    v = $urandom;
    ee.pos_win = v;
    ee.quad_cnt = ~v;
    ee.rot_sense = v[0];
    ee.tune_resp = tr;
    op(1'b1, 1'b0, GRP_BASIC, PN_POS_WIN, v, 0);
    op(1'b1, 1'b0, GRP_BASIC, PN_QUAD_CNT, ~v, 0);
    op(1'b1, 1'b0, GRP_BASIC, PN_ROT_SENSE, {15'h0000, v[0]}, 0);
    op(1'b1, 1'b0, GRP_BASIC, PN_REGEN, 16'h0010, 0);
    `CHK(eff, sbpb_eff_t'{RST_REGEN, RST_FUNC_A1, RST_TUNE_MODE, RST_TUNE_RESP,
      RST_POS_WIN, RST_ROT_SENSE[0], RST_QUAD_CNT, RST_WPROT})
    creset();
    `CHK(eff, ee)
    `CHK(param_error, 1'b0)
    power(2);
    ee.regen = 16'h0010;
    `CHK(eff, ee)
    `CHK({param_error, error_code}, {1'b1, ERR_REGEN})
    op(1'b1, 1'b0, GRP_BASIC, PN_REGEN, 16'h0103, 0);
    power(1);
    `CHK(param_error, 1'b0)
    $display("test staged activation done");
    op(1'b1, 1'b0, GRP_BASIC, PN_ABSPOS, 16'h0001, 0);
    op(1'b1, 1'b0, GRP_BASIC, PN_FUNC_A1, {4'h0, HALT_SEL_OFF, 8'h00}, 0);
    halt_in = 1'b0;
    repeat (5) @(negedge clk);
    `CHK({absolute_mode, halt_released}, 2'b00)
    creset();
    `CHK({absolute_mode, halt_released}, 2'b01)
    position_mode = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(absolute_mode, 1'b1)
    $display("test mode flags done");
    foreach (rsts[k])
    begin
      sw = (k == 0) ? WP_RD_ALL : (k == 1) ? WP_ALL :
           (k == 2) ? WP_SELF_ONLY : WP_STD;
      if (k < 4)
      begin
        op(1'b1, 1'b0, GRP_BASIC, PN_WPROT, sw, 0);
        creset();
        sweep();
        op(1'b1, 1'b0, GRP_BASIC, PN_POS_WIN, ~v, 0);
        if (exp_grant(wp, 1'b1, 1'b0, GRP_BASIC, PN_POS_WIN, ~v))
          v = ~v;
        op(1'b1, 1'b1, GRP_BASIC, PN_POS_WIN, v + 16'h0001, 0);
        v = v + 16'h0001;
        op(1'b0, 1'b0, GRP_BASIC, PN_POS_WIN, 0, v);
        op(1'b0, 1'b1, GRP_BASIC, PN_POS_WIN, 0, v);
      end
    end
    $display("test inhibit settings done");
    test_done();
  end
endmodule : tb
